// File: src/pmc_channel.sv
/*
 One power-management mailbox channel between host and embedded core.
 Assumes host and core requests are synchronous to CLK_SYS one-cycle
 strobes; instantiate once per channel, instances share nothing.
*/
// What this block does
// RQ1: Host write to data or command port loads input latch, sets input-full.
// RQ2: Status bit 3 shows last host write target; core cannot write it.
// RQ3: Core read of either input-read register clears input-full.
// RQ4: Input-full core interrupt asserted while unread data and enable set.
// RQ5: Any output-write register sets output-full; core flag writes ignored.
// RQ6: Firmware writes output latch only while output-full is clear.
// RQ7: Host data read returns output latch and clears output-full.
// RQ8: Level mode with hardware irq enabled: data read drops host irq.
// RQ9: Compatible mode, empty enable: core interrupt high while output empty.
// RQ10: Enhanced mode SCI and SMI output writes raise SCI and SMI.
// RQ11: Status readable by both; only bits 2 and 7-4 core writable.
// RQ12: Host status read returns the same status byte as core.
// RQ13: Reset clears all status bits.
// RQ14: Bit 2 general flag, core set or clear, no side effects.
// RQ15: Bits 7-4 four core-writable signaling flags.
// RQ16: Host polls status or services interrupts before reading data.
// RQ17: Firmware checks command marker before reading input latch.
// RQ18: Plain output write sets output-full with no SCI or SMI.
// RQ19: Enhanced mode SCI input read sets input SCI flag; cleared when input-full sets.
// RQ20: Control bit 7 high selects enhanced mode, low compatible.
// RQ21: Each channel instance independent, no shared state.
// RQ22: Host write while full overwrites latch, updates marker, stays full.
`timescale 1ns/1ns
module pmc_channel
    import pmc_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        CORE_WR,
    input  wire logic        CORE_RD,
    input  wire logic [15:0] CORE_ADDR,
    input  wire logic [7:0]  CORE_WDATA,
    output logic      [7:0]  CORE_RDATA,
    output logic             CORE_IRQ_IBF,
    output logic             CORE_IRQ_OBE,
    input  wire logic        HOST_WR,
    input  wire logic        HOST_RD,
    input  wire logic        HOST_CMD_SEL,
    input  wire logic [7:0]  HOST_WDATA,
    output logic      [7:0]  HOST_RDATA,
    output logic             HOST_IRQ,
    output logic             HOST_SCI,
    output logic             HOST_SMI
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // RQ21: state local to instance
    pmc_state_t    s_r;
    pmc_state_t    s_nxt;
    pmc_core_req_t creq;
    pmc_host_req_t hreq;

    // ------------------------------------------------------------------
    // Address decode and request carriers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        hit = (a == o);
    endfunction

    assign creq = '{wr: CORE_WR, rd: CORE_RD, addr: CORE_ADDR,
                    wdata: CORE_WDATA};
    assign hreq = '{wr: HOST_WR, rd: HOST_RD, cmd_sel: HOST_CMD_SEL,
                    wdata: HOST_WDATA};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic out_wr;
        logic in_rd;
        logic enh;
        logic host_dread;
        out_wr     = 1'b0;
        in_rd      = 1'b0;
        host_dread = 1'b0;
        s_nxt      = s_r;
        // RQ20: mode select bit
        enh = s_r.ctrl[`PMC_CTL_EME];

        // Core reads
        // Read data answers one cycle, zero when idle
        s_nxt.core_rdata = 8'h00;
        if (creq.rd) begin
            case (creq.addr)
                `PMC_OFS_STATUS: s_nxt.core_rdata = s_r.status;
                `PMC_OFS_IN_PLAIN,
                `PMC_OFS_IN_SCI: begin
                    s_nxt.core_rdata = s_r.in_latch;
                    in_rd = 1'b1;
                end
                `PMC_OFS_CTRL:    s_nxt.core_rdata = s_r.ctrl;
                `PMC_OFS_IRQ_CFG: s_nxt.core_rdata = s_r.irq_cfg;
                default:          s_nxt.core_rdata = 8'h00;
            endcase
        end
        // RQ3: input read clears full
        if (in_rd) begin
            s_nxt.status[`PMC_ST_IBF] = 1'b0;
        end
        // RQ19: SCI input read flag
        if (creq.rd && hit(creq.addr, `PMC_OFS_IN_SCI) && enh) begin
            s_nxt.in_sci = 1'b1;
        end

        // Core writes
        if (creq.wr) begin
            case (creq.addr)
                // RQ11: masked status write
                `PMC_OFS_STATUS: begin
                    // RQ14: general flag
                    // RQ15: signaling flags
                    // Bits 0, 1 and 3 stay with hardware
                    s_nxt.status = (s_r.status & ~`PMC_ST_CORE_WMASK)
                                 | (creq.wdata & `PMC_ST_CORE_WMASK);
                    if (in_rd) begin
                        s_nxt.status[`PMC_ST_IBF] = 1'b0;
                    end
                end
                `PMC_OFS_OUT_PLAIN,
                `PMC_OFS_OUT_SCI,
                `PMC_OFS_OUT_SMI: out_wr = 1'b1;
                `PMC_OFS_CTRL:    s_nxt.ctrl    = creq.wdata;
                `PMC_OFS_IRQ_CFG: s_nxt.irq_cfg = creq.wdata;
                default:          out_wr = 1'b0;
            endcase
        end

        // Host access
        // Host read data holds until the next host read
        s_nxt.host_rdata = s_r.host_rdata;
        if (hreq.rd) begin
            // RQ12: host status view
            if (hreq.cmd_sel) begin
                s_nxt.host_rdata = s_r.status;
            end else begin
                // RQ7: data read clears full
                s_nxt.host_rdata = s_r.out_latch;
                host_dread = 1'b1;
                s_nxt.status[`PMC_ST_OBF] = 1'b0;
                s_nxt.out_sci = 1'b0;
                s_nxt.out_smi = 1'b0;
            end
        end
        // Core output write wins over a same-cycle host read
        // RQ5: output write sets full
        if (out_wr) begin
            s_nxt.out_latch = creq.wdata;
            s_nxt.status[`PMC_ST_OBF] = 1'b1;
            // RQ18: plain write no pulses
            // RQ10: enhanced SCI and SMI
            s_nxt.out_sci = enh && hit(creq.addr, `PMC_OFS_OUT_SCI);
            s_nxt.out_smi = enh && hit(creq.addr, `PMC_OFS_OUT_SMI);
        end
        // Host write wins over a same-cycle core input read
        // RQ1: host write loads latch
        // RQ22: overwrite while full
        if (hreq.wr) begin
            s_nxt.in_latch = hreq.wdata;
            s_nxt.status[`PMC_ST_IBF] = 1'b1;
            // RQ2: command marker
            s_nxt.status[`PMC_ST_CMD] = hreq.cmd_sel;
            s_nxt.in_sci = 1'b0;
        end

        // Host irq, level mode follows output-full
        if (s_r.irq_cfg[`PMC_CFG_HIRQ_EN]) begin
            // RQ8: level irq drop on read
            if (s_r.irq_cfg[`PMC_CFG_HOST_IRQ_MODE_FIELD_LO +: 3] == `PMC_HOST_IRQ_MODE_FIELD_LEVEL) begin
                s_nxt.host_irq = s_nxt.status[`PMC_ST_OBF] && !host_dread;
            end else begin
                s_nxt.host_irq = 1'b0;
            end
        end else begin
            s_nxt.host_irq = 1'b0;
        end

        // RQ4: input-full core irq
        s_nxt.core_irq_ibf = s_r.ctrl[`PMC_CTL_IBF_IE]
                           && s_nxt.status[`PMC_ST_IBF];
        // RQ9: output-empty core irq
        s_nxt.core_irq_obe = s_r.ctrl[`PMC_CTL_OBE_IE]
                           && !s_nxt.status[`PMC_ST_OBF];

        // RQ19: SCI from both flags
        s_nxt.host_sci = s_nxt.out_sci | s_nxt.in_sci;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s_r <= '0;
            // RQ13: status cleared
            s_r.status  <= `PMC_ST_RESET;
            // Control leaves reset at 0x40
            s_r.ctrl    <= `PMC_CTL_RESET;
            s_r.irq_cfg <= `PMC_CFG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign CORE_RDATA   = s_r.core_rdata;
    assign CORE_IRQ_IBF = s_r.core_irq_ibf;
    assign CORE_IRQ_OBE = s_r.core_irq_obe;
    assign HOST_RDATA   = s_r.host_rdata;
    assign HOST_IRQ     = s_r.host_irq;
    assign HOST_SCI     = s_r.host_sci;
    assign HOST_SMI     = s_r.out_smi;

endmodule

// File: src/pmc_defs.svh
/*
 Constants for the power-management mailbox channel: core register
 offsets, status and control field positions, reset values and host irq mode codes.
 Assumes inclusion from the package, the checker and the bench.
*/
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ----------------------------------------------------------------------
// Core register offsets (channel 1 map)
// ----------------------------------------------------------------------
`define PMC_OFS_STATUS      16'hfeac
`define PMC_OFS_OUT_PLAIN   16'hfeae
`define PMC_OFS_IN_PLAIN    16'hfeb0
`define PMC_OFS_OUT_SCI     16'hfeb2
`define PMC_OFS_OUT_SMI     16'hfeb4
`define PMC_OFS_IN_SCI      16'hfeb6
`define PMC_OFS_CTRL        16'hfeb8
`define PMC_OFS_IRQ_CFG     16'hfeba

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define PMC_ST_OBF          0
`define PMC_ST_IBF          1
`define PMC_ST_GEN          2
`define PMC_ST_CMD          3
`define PMC_ST_CORE_WMASK   8'hf4
`define PMC_ST_RESET        8'h00

// ----------------------------------------------------------------------
// Control and host irq config fields
// ----------------------------------------------------------------------
`define PMC_CTL_IBF_IE      0
`define PMC_CTL_OBE_IE      1
`define PMC_CTL_EME         7
`define PMC_CTL_RESET       8'h40
`define PMC_CFG_HIRQ_EN     3
`define PMC_CFG_HOST_IRQ_MODE_FIELD_LO     0
`define PMC_CFG_RESET       8'h00
`define PMC_HOST_IRQ_MODE_FIELD_LEVEL      3'h0

`endif

// File: src/pmc_pkg.sv
/*
 Types for the power-management mailbox channel.
 Assumes pmc_defs.svh is on the include path.
*/
package pmc_pkg;
    `include "pmc_defs.svh"

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pmc_core_req_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       cmd_sel;
        logic [7:0] wdata;
    } pmc_host_req_t;

    typedef struct packed {
        logic [7:0] in_latch;
        logic [7:0] out_latch;
        logic [7:0] status;
        logic [7:0] ctrl;
        logic [7:0] irq_cfg;
        logic       in_sci;
        logic       out_sci;
        logic       out_smi;
        logic [7:0] core_rdata;
        logic [7:0] host_rdata;
        logic       host_irq;
        logic       core_irq_ibf;
        logic       core_irq_obe;
        logic       host_sci;
    } pmc_state_t;
endpackage

// File: tb/pmc_channel_sva.sv
/* Port checker for pmc_channel.
 Assumes a bind into each pmc_channel, one clock domain. */
`timescale 1ns/1ns
`include "pmc_defs.svh"
module pmc_channel_sva (
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic        CORE_WR,
    input wire logic        CORE_RD,
    input wire logic [15:0] CORE_ADDR,
    input wire logic [7:0]  CORE_WDATA,
    input wire logic [7:0]  CORE_RDATA,
    input wire logic        CORE_IRQ_IBF,
    input wire logic        CORE_IRQ_OBE,
    input wire logic        HOST_WR,
    input wire logic        HOST_RD,
    input wire logic        HOST_CMD_SEL,
    input wire logic [7:0]  HOST_RDATA,
    input wire logic        HOST_IRQ,
    input wire logic        HOST_SCI,
    input wire logic        HOST_SMI
);
    logic [7:0] ctl_r;
    logic [7:0] cfg_r;
    logic       ow;
    logic       ir;
    logic       hd;
    assign ow = CORE_WR && CORE_ADDR inside {`PMC_OFS_OUT_PLAIN,
                `PMC_OFS_OUT_SCI, `PMC_OFS_OUT_SMI};
    assign ir = CORE_RD && CORE_ADDR inside {`PMC_OFS_IN_PLAIN,
                `PMC_OFS_IN_SCI};
    assign hd = HOST_RD && !HOST_CMD_SEL && !CORE_WR;
    // Shadow of control and host irq config
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctl_r <= `PMC_CTL_RESET;
            cfg_r <= `PMC_CFG_RESET;
        end else if (CORE_WR && CORE_ADDR == `PMC_OFS_CTRL) begin
            ctl_r <= CORE_WDATA;
        end else if (CORE_WR && CORE_ADDR == `PMC_OFS_IRQ_CFG) begin
            cfg_r <= CORE_WDATA;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    a_irq_drop: assert property (hd |=> !HOST_IRQ)
        else $error("host irq kept after data read");
    a_irq_rise: assert property (ow && cfg_r[3] &&
        cfg_r[2:0] == 3'h0 |=> HOST_IRQ)
        else $error("host irq not raised on output write");
    a_smi_drop: assert property (hd |=> !HOST_SMI)
        else $error("smi kept after data read");
    a_smi_raise: assert property (CORE_WR && ctl_r[7] &&
        CORE_ADDR == `PMC_OFS_OUT_SMI |=> HOST_SMI)
        else $error("smi not raised");
    a_sci_raise: assert property (CORE_WR && ctl_r[7] &&
        CORE_ADDR == `PMC_OFS_OUT_SCI |=> HOST_SCI)
        else $error("sci not raised");
    a_obe_low: assert property (ow |=> !CORE_IRQ_OBE)
        else $error("empty irq kept after output write");
    a_obe_raise: assert property (hd && ctl_r[1] |=> CORE_IRQ_OBE)
        else $error("empty irq not raised");
    a_ibf_low: assert property (ir && !HOST_WR |=> !CORE_IRQ_IBF)
        else $error("full irq kept after input read");
    a_ibf_raise: assert property (HOST_WR && !CORE_WR && ctl_r[0]
        |=> CORE_IRQ_IBF)
        else $error("full irq not raised");
    a_mark_bits: assert property (
        HOST_WR && !CORE_RD ##1 !HOST_WR && !CORE_RD ##1
        (CORE_RD && !HOST_WR && CORE_ADDR == `PMC_OFS_STATUS) |=>
        CORE_RDATA[1] && CORE_RDATA[3] == $past(HOST_CMD_SEL, 3))
        else $error("status full or marker wrong");
    a_rd_hold: assert property (!HOST_RD |=> $stable(HOST_RDATA))
        else $error("host read data changed");
    c_data_rd: cover property (hd);
    c_in_rd: cover property (ir);
    c_smi: cover property (CORE_WR && CORE_ADDR == `PMC_OFS_OUT_SMI);
endmodule
bind pmc_channel pmc_channel_sva chk_u (.*);

// File: tb/pmc_host_model.sv
/* Host side model: port writes and reads, one strobe each.
 Assumes the bench queues the expected read data. */
`timescale 1ns/1ns
module pmc_host_model
    import pmc_pkg::*;
(
    input wire logic CLK_SYS,
    output pmc_host_req_t req
);
    initial req = '0;
    // Released cmd and data lines show inverted values, strobes go low
    task automatic xfer(input logic wr, input logic cmd,
                        input logic [7:0] v);
        @(posedge CLK_SYS);
        req <= '{wr, ~wr, cmd, v};
        @(posedge CLK_SYS);
        req <= '{1'b0, 1'b0, ~cmd, ~v};
        @(negedge CLK_SYS);
    endtask
endmodule

// File: tb/pmc_channel_test.sv
/* Self-checking bench for pmc_channel.
 Assumes pmc_host_model drives the host side. */
`timescale 1ns/1ns
`include "pmc_defs.svh"
module pmc_channel_test
    import pmc_pkg::*;
;
    logic          clk;
    logic          rstn;
    pmc_core_req_t c;
    pmc_host_req_t h;
    logic [7:0]    crd, hrd, d;
    logic          iib, iob, hirq, sci, smi, crd_d, hrd_d;
    logic [7:0]    q[$];
    int            num_errors = 0;
    int            check_count = 0;
    pmc_channel dut_u (.CLK_SYS(clk), .RSTN(rstn), .CORE_WR(c.wr),
        .CORE_RD(c.rd), .CORE_ADDR(c.addr), .CORE_WDATA(c.wdata),
        .CORE_RDATA(crd), .CORE_IRQ_IBF(iib), .CORE_IRQ_OBE(iob),
        .HOST_WR(h.wr), .HOST_RD(h.rd), .HOST_CMD_SEL(h.cmd_sel),
        .HOST_WDATA(h.wdata), .HOST_RDATA(hrd), .HOST_IRQ(hirq),
        .HOST_SCI(sci), .HOST_SMI(smi));
    pmc_host_model host_u (.CLK_SYS(clk), .req(h));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic core(input logic wr, input logic [15:0] a,
                        input logic [7:0] v);
        if (!wr) q.push_back(v);
        @(posedge clk);
        c <= '{wr, ~wr, a, v};
        @(posedge clk);
        c <= '{1'b0, 1'b0, ~a, ~v};
        @(negedge clk);
    endtask
    task automatic host(input logic wr, input logic cmd,
                        input logic [7:0] v);
        if (!wr) q.push_back(v);
        host_u.xfer(wr, cmd, v);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Read data compared one cycle after the strobe
    always @(posedge clk) begin
        crd_d <= c.rd;
        hrd_d <= h.rd;
    end
    always @(negedge clk) begin
        if (crd_d === 1'b1) chk(crd, q.pop_front());
        if (hrd_d === 1'b1) chk(hrd, q.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        summarize();
    end
    initial begin
        c = '0;
        rstn = 1'b0;
        void'($urandom(4));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        core(0, `PMC_OFS_STATUS, 8'h00);
        core(0, 16'hfe00, 8'h00);
        chk({3'h0, iib, iob, hirq, sci, smi}, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            host(1, i[0], ~d);
            host(1, ~i[0], d);
            core(0, `PMC_OFS_STATUS, {4'h0, ~i[0], 3'h2});
            core(0, i ? `PMC_OFS_IN_SCI : `PMC_OFS_IN_PLAIN, d);
            core(0, `PMC_OFS_STATUS, {4'h0, ~i[0], 3'h0});
        end
        $display("test inbound done");
        core(1, `PMC_OFS_STATUS, 8'hff);
        core(0, `PMC_OFS_STATUS, 8'hf4);
        host(0, 1, 8'hf4);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        core(0, `PMC_OFS_STATUS, 8'h00);
        $display("test status done");
        core(1, `PMC_OFS_CTRL, 8'h83);
        core(1, `PMC_OFS_IRQ_CFG, 8'h08);
        chk({7'h0, iob}, 8'h01);
        core(1, `PMC_OFS_OUT_SMI, d);
        chk({4'h0, iob, hirq, sci, smi}, 8'h05);
        core(0, `PMC_OFS_STATUS, 8'h01);
        host(0, 0, d);
        chk({4'h0, iob, hirq, sci, smi}, 8'h08);
        core(1, `PMC_OFS_OUT_SCI, ~d);
        chk({6'h0, sci, smi}, 8'h02);
        host(0, 0, ~d);
        core(1, `PMC_OFS_OUT_PLAIN, d);
        chk({6'h0, sci, smi}, 8'h00);
        host(0, 0, d);
        host(1, 0, d);
        chk({7'h0, iib}, 8'h01);
        core(0, `PMC_OFS_IN_SCI, d);
        chk({6'h0, iib, sci}, 8'h01);
        host(1, 1, d);
        chk({6'h0, iib, sci}, 8'h02);
        core(0, `PMC_OFS_IN_PLAIN, d);
        $display("test enhanced done");
        core(1, `PMC_OFS_CTRL, 8'h02);
        core(1, `PMC_OFS_IRQ_CFG, 8'h09);
        core(1, `PMC_OFS_OUT_PLAIN, d);
        chk({6'h0, iob, hirq}, 8'h00);
        host(0, 0, d);
        chk({7'h0, iob}, 8'h01);
        core(1, `PMC_OFS_OUT_SCI, ~d);
        chk({6'h0, sci, smi}, 8'h00);
        host(0, 0, ~d);
        $display("test compatible done");
        summarize();
    end
endmodule
